// [design/txn_status_params.svh]
// Offsets, field positions, reset values and codes of the status block.
`ifndef TXN_STATUS_PARAMS_SVH
`define TXN_STATUS_PARAMS_SVH

// ==========================================================
// Register offsets
`define TTS_OFFSET 8'h60
`define IRQ_STAT_OFFSET 8'h70
`define IRQ_MASK_OFFSET 8'h74

// ==========================================================
// Reset values
`define TTS_RESET 32'hfa000000
`define DONE_RESET 6'h3f
`define SEL_RESET 4'h0
`define IRQ_RESET 8'h00

// ==========================================================
// Field positions, bit 0 of the map is bit 31 of the word
`define DONE_POS(i) (((i) == 5) ? 25 : (31 - (i)))
`define ERR_DTX_POS 23
`define ERR_DRX_POS 22
`define SEL_MSB 7
`define SEL_LSB 4
`define ABORT_POS 3

// ==========================================================
// Timer select codes
`define SEL_DATA_TX 4'h0
`define SEL_DATA_RX 4'h1
`define SEL_MGMT 4'h2
`define SEL_CTRL 4'h4
`define SEL_AUTORESP 4'h6

// ==========================================================
// Bus answers
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// [design/txn_status_pkg.sv]
// Types shared by the transaction status block and its users.
package txn_status_pkg;

	// ==========================================================
	// Sources, in flag order
	typedef enum logic [2:0] {
		SRC_DATA_TX,
		SRC_DATA_RX,
		SRC_ASYNC_TX,
		SRC_MGMT_TX,
		SRC_CTRL_TX,
		SRC_AUTORESP
	} src_t;

	// ==========================================================
	// Transaction events, one bit per source, one-cycle pulses
	typedef struct packed {
		logic [5:0] start;
		logic [5:0] done;
		logic [5:0] error;
	} txn_evt_t;

	// ==========================================================
	// Abort request to the timer engine
	typedef struct packed {
		logic fire;
		logic [3:0] sel;
	} abort_t;

endpackage

// [design/request_fifo_txn_status.sv]
// Transaction timer status register with AXI4-Lite slave and interrupt.
// Contract
// - Timer status register reports progress of every request FIFO transaction.
// - The status register holds fa000000 after power-on reset.
// - Bus reset changes only the bits defined to change on it.
// - Bit 0 sets on data transmit completion, clears on begin, resets to one.
// - Bit 1 does the same for the data receive FIFO.
// - Bit 2 does the same for the asynchronous transmit FIFO.
// - Bit 3 does the same for the management transmit queue.
// - Bit 4 does the same for the control transmit queue.
// - Bit 6 does the same for autoresponse; bits 5 and 7 reserved.
// - Bit 8 flags data transmit error end; clean end or begin clears it.
// - Aborting a data transmit transaction also sets the transmit error flag.
// - Bit 9 flags data receive error end; bus reset leaves it alone.
// - Writing one to bit 28 aborts the selected timer, then self-clears.
// - Bits 24 to 27 choose the timer that abort acts on.
`include "txn_status_params.svh"
`timescale 1ns/1ns
`default_nettype none

module request_fifo_txn_status (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Link layer events
	input wire logic bus_reset,
	input wire txn_status_pkg::txn_evt_t evt,
	output txn_status_pkg::abort_t abort_req,
	output logic irq,
	// AXI4-Lite write
	input wire logic [7:0] awaddr,
	input wire logic awvalid,
	output logic awready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	// AXI4-Lite read
	input wire logic [7:0] araddr,
	input wire logic arvalid,
	output logic arready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready
);

	// ==========================================================
	// Write channel state
	logic aw_full_q, aw_full_d, w_full_q, w_full_d;
	logic [7:0] awaddr_q, awaddr_d;
	logic [31:0] wdata_q, wdata_d;
	logic [3:0] wstrb_q, wstrb_d;
	logic awready_q, awready_d, wready_q, wready_d;
	logic bvalid_q, bvalid_d;
	logic [1:0] bresp_q, bresp_d;
	logic do_wr, wr_tts, wr_stat, wr_mask;

	always_comb begin
		aw_full_d = aw_full_q;
		w_full_d = w_full_q;
		awaddr_d = awaddr_q;
		wdata_d = wdata_q;
		wstrb_d = wstrb_q;
		bvalid_d = bvalid_q;
		bresp_d = bresp_q;
		do_wr = aw_full_q && w_full_q && !bvalid_q;
		wr_tts = do_wr && awaddr_q == `TTS_OFFSET;
		wr_stat = do_wr && awaddr_q == `IRQ_STAT_OFFSET;
		wr_mask = do_wr && awaddr_q == `IRQ_MASK_OFFSET;
		if (awvalid && awready_q) begin
			aw_full_d = 1'b1;
			awaddr_d = awaddr;
		end
		if (wvalid && wready_q) begin
			w_full_d = 1'b1;
			wdata_d = wdata;
			wstrb_d = wstrb;
		end
		if (do_wr) begin
			aw_full_d = 1'b0;
			w_full_d = 1'b0;
			bvalid_d = 1'b1;
			bresp_d = (wr_tts || wr_stat || wr_mask) ?
				`RESP_OKAY : `RESP_SLVERR;
		end
		if (bvalid_q && bready) begin
			bvalid_d = 1'b0;
		end
		awready_d = !aw_full_d;
		wready_d = !w_full_d;
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			aw_full_q <= 1'b0;
			w_full_q <= 1'b0;
			awaddr_q <= 8'h00;
			wdata_q <= 32'h00000000;
			wstrb_q <= 4'h0;
			awready_q <= 1'b1;
			wready_q <= 1'b1;
			bvalid_q <= 1'b0;
			bresp_q <= `RESP_OKAY;
		end else begin
			aw_full_q <= aw_full_d;
			w_full_q <= w_full_d;
			awaddr_q <= awaddr_d;
			wdata_q <= wdata_d;
			wstrb_q <= wstrb_d;
			awready_q <= awready_d;
			wready_q <= wready_d;
			bvalid_q <= bvalid_d;
			bresp_q <= bresp_d;
		end
	end

	// ==========================================================
	// Timer status flags and control fields
	logic [5:0] done_q, done_d;
	logic dtx_err_q, dtx_err_d, drx_err_q, drx_err_d;
	logic [3:0] sel_q, sel_d;
	logic abort_q, abort_d;
	logic dtx_abort;
	logic [31:0] tts;

	always_comb begin
		// Abort of the data transmit timer counts as an error end.
		dtx_abort = abort_q && sel_q == `SEL_DATA_TX;
		for (int i = 0; i < 6; i++) begin
			done_d[i] = done_q[i];
			if (bus_reset) begin
				done_d[i] = 1'b1;
			end else if (evt.done[i]) begin
				done_d[i] = 1'b1;
			end else if (evt.start[i]) begin
				done_d[i] = 1'b0;
			end
		end
		dtx_err_d = dtx_err_q;
		if ((evt.done[0] && evt.error[0]) || dtx_abort) begin
			dtx_err_d = 1'b1;
		end else if (evt.done[0] || evt.start[0]) begin
			dtx_err_d = 1'b0;
		end
		drx_err_d = drx_err_q;
		if (evt.done[1] && evt.error[1]) begin
			drx_err_d = 1'b1;
		end else if (evt.done[1] || evt.start[1]) begin
			drx_err_d = 1'b0;
		end
		sel_d = sel_q;
		abort_d = 1'b0;
		if (wr_tts && wstrb_q[0]) begin
			sel_d = wdata_q[`SEL_MSB:`SEL_LSB];
			abort_d = wdata_q[`ABORT_POS];
		end
		if (bus_reset) begin
			sel_d = `SEL_RESET;
			abort_d = 1'b0;
		end
		tts = 32'h00000000;
		for (int i = 0; i < 6; i++) begin
			tts[`DONE_POS(i)] = done_q[i];
		end
		tts[`ERR_DTX_POS] = dtx_err_q;
		tts[`ERR_DRX_POS] = drx_err_q;
		tts[`SEL_MSB:`SEL_LSB] = sel_q;
		tts[`ABORT_POS] = abort_q;
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			done_q <= `DONE_RESET;
			dtx_err_q <= 1'b0;
			drx_err_q <= 1'b0;
			sel_q <= `SEL_RESET;
			abort_q <= 1'b0;
		end else begin
			done_q <= done_d;
			dtx_err_q <= dtx_err_d;
			drx_err_q <= drx_err_d;
			sel_q <= sel_d;
			abort_q <= abort_d;
		end
	end

	// ==========================================================
	// Interrupt status and mask
	logic [7:0] stat_q, stat_d, mask_q, mask_d, ev;
	logic irq_q, irq_d;

	always_comb begin
		ev = {evt.done[1] && evt.error[1],
			(evt.done[0] && evt.error[0]) || dtx_abort, evt.done};
		stat_d = stat_q;
		if (wr_stat && wstrb_q[0]) begin
			stat_d = stat_d & ~wdata_q[7:0];
		end
		stat_d = stat_d | ev;
		mask_d = mask_q;
		if (wr_mask && wstrb_q[0]) begin
			mask_d = wdata_q[7:0];
		end
		irq_d = |(stat_q & mask_q);
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			stat_q <= `IRQ_RESET;
			mask_q <= `IRQ_RESET;
			irq_q <= 1'b0;
		end else begin
			stat_q <= stat_d;
			mask_q <= mask_d;
			irq_q <= irq_d;
		end
	end

	// ==========================================================
	// Read channel
	logic arready_q, arready_d, rvalid_q, rvalid_d;
	logic [31:0] rdata_q, rdata_d;
	logic [1:0] rresp_q, rresp_d;

	always_comb begin
		arready_d = arready_q;
		rvalid_d = rvalid_q;
		rdata_d = rdata_q;
		rresp_d = rresp_q;
		if (arvalid && arready_q) begin
			arready_d = 1'b0;
			rvalid_d = 1'b1;
			rresp_d = `RESP_OKAY;
			case (araddr)
				`TTS_OFFSET: rdata_d = tts;
				`IRQ_STAT_OFFSET: rdata_d = {24'h000000, stat_q};
				`IRQ_MASK_OFFSET: rdata_d = {24'h000000, mask_q};
				default: begin
					rdata_d = 32'h00000000;
					rresp_d = `RESP_SLVERR;
				end
			endcase
		end
		if (rvalid_q && rready) begin
			rvalid_d = 1'b0;
			arready_d = 1'b1;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			arready_q <= 1'b1;
			rvalid_q <= 1'b0;
			rdata_q <= 32'h00000000;
			rresp_q <= `RESP_OKAY;
		end else begin
			arready_q <= arready_d;
			rvalid_q <= rvalid_d;
			rdata_q <= rdata_d;
			rresp_q <= rresp_d;
		end
	end

	// ==========================================================
	// Outputs
	assign awready = awready_q;
	assign wready = wready_q;
	assign bvalid = bvalid_q;
	assign bresp = bresp_q;
	assign arready = arready_q;
	assign rvalid = rvalid_q;
	assign rdata = rdata_q;
	assign rresp = rresp_q;
	assign irq = irq_q;
	assign abort_req = {abort_q, sel_q};

	// ==========================================================
	// Checks
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (rst);

	a_reset_value: assert property ($fell(rst) |-> tts == `TTS_RESET)
		else $error("status word wrong after reset");
	a_bus_reset_done: assert property (bus_reset |=> &done_q)
		else $error("bus reset did not set end flags");
	a_bus_reset_err: assert property (bus_reset && !dtx_abort
		&& !evt.done[0] && !evt.start[0]
		&& !evt.done[1] && !evt.start[1]
		|=> $stable(dtx_err_q) && $stable(drx_err_q))
		else $error("bus reset moved error flags");
	a_done_set: assert property (evt.done[0] |=> done_q[0])
		else $error("end flag did not set on completion");
	a_done_clear: assert property (!bus_reset && evt.start[0]
		&& !evt.done[0] |=> !done_q[0])
		else $error("end flag did not clear on begin");
	a_done_fall: assert property (!bus_reset && evt.start[5]
		&& !evt.done[5] |=> !tts[25])
		else $error("autoresponse end flag wrong");
	a_dtx_abort: assert property (wr_tts && wstrb_q[0]
		&& wdata_q[`ABORT_POS] && !bus_reset
		&& wdata_q[`SEL_MSB:`SEL_LSB] == `SEL_DATA_TX
		|=> abort_req.fire ##1 !abort_req.fire && dtx_err_q)
		else $error("abort did not set transmit error");
	a_drx_err: assert property (evt.done[1] && evt.error[1]
		|=> drx_err_q ##0 tts[`ERR_DRX_POS])
		else $error("receive error flag not set");
	a_sel_write: assert property (wr_tts && wstrb_q[0] && !bus_reset
		|=> sel_q == $past(wdata_q[`SEL_MSB:`SEL_LSB]))
		else $error("timer select not stored");
	a_abort_clear: assert property (abort_q |=> !abort_q)
		else $error("abort bit did not self-clear");
	a_irq_level: assert property (|(stat_q & mask_q) |=> irq)
		else $error("interrupt not raised");

endmodule

`default_nettype wire

// [verif/txn_link_model.sv]
// Link layer model that issues supervised transactions.
`timescale 1ns/1ns
`default_nettype none

module txn_link_model (
	// Clock
	input wire logic clk,
	// Commands of the bench
	input wire logic kick,
	input wire logic [2:0] src,
	input wire logic fail,
	// Events to the status block
	output wire txn_status_pkg::txn_evt_t evt
);
	// ==========================================================
	// Begin pulse, then an end pulse fifteen cycles later.
	txn_status_pkg::txn_evt_t ev_q = '0;
	logic [3:0] cnt_q = 4'h0;
	logic [2:0] src_q = 3'h0;
	logic fail_q = 1'h0;
	assign evt = ev_q;
	always @(posedge clk) begin
		ev_q <= '0;
		if (kick) begin
			src_q <= src;
			fail_q <= fail;
			cnt_q <= 4'hf;
			ev_q.start[src] <= 1'h1;
		end else if (cnt_q != 4'h0) begin
			cnt_q <= cnt_q - 4'h1;
			if (cnt_q == 4'h1) begin
				ev_q.done[src_q] <= 1'h1;
				ev_q.error[src_q] <= fail_q;
			end
		end
	end
endmodule

`default_nettype wire

// [verif/request_fifo_txn_status_tb_top.sv]
// Self-checking bench of the transaction status block.
`timescale 1ns/1ns
`default_nettype none
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin num_errors++; $display("[ERR] %s exp %h got %h", n, e, g); end end

module request_fifo_txn_status_tb_top;
	// ==========================================================
	// Signals and instances
	logic clk = 1'h0, rst = 1'h1, bus_reset = 1'h0;
	logic kick = 1'h0, fail = 1'h0, irq;
	logic [2:0] src = 3'h0;
	txn_status_pkg::txn_evt_t evt;
	txn_status_pkg::abort_t abort_req;
	logic [7:0] awaddr = 8'h0, araddr = 8'h0;
	logic [31:0] wdata = 32'h0, rdata, rd;
	logic [3:0] wstrb = 4'hf, sel = 4'h0, fsel;
	logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0;
	logic arvalid = 1'h0, rready = 1'h0;
	logic awready, wready, bvalid, arready, rvalid;
	logic [1:0] bresp, rresp, rs;
	logic [5:0] dn = 6'h3f;
	logic etx = 1'h0, erx = 1'h0;
	logic [3:0] codes [5] = '{4'h0, 4'h1, 4'h2, 4'h4, 4'h6};
	int num_errors = 0, checks = 0, wt = 0, fires = 0;

	request_fifo_txn_status dut_u (.clk(clk), .rst(rst),
		.bus_reset(bus_reset), .evt(evt), .abort_req(abort_req), .irq(irq),
		.awaddr(awaddr), .awvalid(awvalid), .awready(awready),
		.wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
		.bresp(bresp), .bvalid(bvalid), .bready(bready),
		.araddr(araddr), .arvalid(arvalid), .arready(arready),
		.rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready));
	txn_link_model link_u (.clk(clk), .kick(kick), .src(src),
		.fail(fail), .evt(evt));

	initial begin
		forever #10 clk = ~clk;
	end
	always @(posedge clk) begin
		if (abort_req.fire === 1'h1) begin
			fires <= fires + 1;
			fsel <= abort_req.sel;
		end
	end

	// ==========================================================
	// Tasks and expectations
	task automatic complete_run();
		if (num_errors == 0 && checks > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask
	task automatic step();
		@(posedge clk);
		wt++;
		if (wt > 100) begin
			num_errors++;
			complete_run();
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic ta, tw;
		ta = 1'h0;
		tw = 1'h0;
		wt = 0;
		@(posedge clk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'h1;
		wvalid <= 1'h1;
		bready <= 1'h1;
		do begin
			step();
			ta |= awready;
			tw |= wready;
			if (ta) awvalid <= 1'h0;
			if (tw) wvalid <= 1'h0;
		end while (!(ta && tw));
		while (bvalid !== 1'h1) step();
		rs = bresp;
		bready <= 1'h0;
	endtask
	task automatic rdr(input logic [7:0] a);
		wt = 0;
		@(posedge clk);
		araddr <= a;
		arvalid <= 1'h1;
		rready <= 1'h1;
		do begin
			step();
			if (arready) arvalid <= 1'h0;
		end while (rvalid !== 1'h1);
		rd = rdata;
		rs = rresp;
		rready <= 1'h0;
	endtask
	function automatic logic [31:0] ew();
		logic [31:0] w;
		w = 32'h0;
		for (int i = 0; i < 6; i++) w[i == 5 ? 25 : 31 - i] = dn[i];
		w[23] = etx;
		w[22] = erx;
		w[7:4] = sel;
		return w;
	endfunction
	task automatic txn(input logic [2:0] s, input logic f);
		@(posedge clk);
		src <= s;
		fail <= f;
		kick <= 1'h1;
		@(posedge clk);
		kick <= 1'h0;
		repeat (3) @(posedge clk);
		dn[s] = 1'h0;
		if (s == 3'h0) etx = 1'h0;
		if (s == 3'h1) erx = 1'h0;
		rdr(8'h60);
		`CHK("begin", ew(), rd)
		repeat (16) @(posedge clk);
		dn[s] = 1'h1;
		if (s == 3'h0) etx = f;
		if (s == 3'h1) erx = f;
		rdr(8'h60);
		`CHK("end", ew(), rd)
	endtask

	initial begin
		void'($urandom(39));
		repeat (10) @(posedge clk);
		rst <= 1'h0;
		rdr(8'h60);
		`CHK("reset", 32'hfa000000, rd)
		wr(8'h60, 32'hffffff50);
		sel = 4'h5;
		rdr(8'h60);
		`CHK("ro bits", ew(), rd)
		for (int k = 0; k < 6; k++) txn(3'(k), 1'h1);
		repeat (12) txn(3'($urandom % 6), 1'($urandom));
		`CHK("irq idle", 1'h0, irq)
		wr(8'h60, 32'h20);
		sel = 4'h2;
		txn(3'h0, 1'h1);
		txn(3'h1, 1'h1);
		@(posedge clk);
		src <= 3'h3;
		kick <= 1'h1;
		@(posedge clk);
		kick <= 1'h0;
		bus_reset <= 1'h1;
		@(posedge clk);
		bus_reset <= 1'h0;
		dn = 6'h3f;
		sel = 4'h0;
		rdr(8'h60);
		`CHK("bus reset", ew(), rd)
		txn(3'h0, 1'h0);
		foreach (codes[k]) begin
			wr(8'h60, {24'h0, codes[k], 4'h8});
			sel = codes[k];
			if (codes[k] == 4'h0) etx = 1'h1;
			rdr(8'h60);
			`CHK("abort", ew(), rd)
			`CHK("fire sel", codes[k], fsel)
		end
		`CHK("fires", 5, fires)
		wr(8'h70, 32'hff);
		wr(8'h74, 32'h01);
		txn(3'h0, 1'h0);
		rdr(8'h70);
		`CHK("irq stat", 32'h01, rd)
		`CHK("irq on", 1'h1, irq)
		wr(8'h74, 32'h0);
		rdr(8'h74);
		`CHK("irq mask", 33'h0, {irq, rd})
		wr(8'h74, 32'h01);
		wr(8'h70, 32'h01);
		rdr(8'h70);
		`CHK("irq clr", 33'h0, {irq, rd})
		rdr(8'h64);
		`CHK("unmapped", 34'h200000000, {rs, rd})
		wr(8'h64, 32'hff);
		`CHK("unmapped wr", 2'h2, rs)
		complete_run();
	end
endmodule

`default_nettype wire
